// File: pkg/ufb_pkg.sv
// Package: register map, field layouts and frame helpers of the serial format block
package ufb_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam int         DIV_W        = 12;
  localparam logic [7:0] OFS_FMT      = 8'h00;
  localparam logic [7:0] OFS_DIV_HI   = 8'h04;
  localparam logic [7:0] OFS_DIV_LO   = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0C;
  localparam logic [7:0] OFS_STAT     = 8'h10;
  localparam logic [7:0] OFS_TXD      = 8'h14;
  localparam logic [7:0] OFS_RXD      = 8'h18;
  localparam logic [7:0] OFS_IRQ_ST   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FMT_RST      = 8'h06;
  localparam int         CTRL_SIZE_HI = 2;
  localparam int         CTRL_TX_EN   = 3;
  localparam int         CTRL_RX_EN   = 4;
  localparam int         STAT_DBL     = 1;
  localparam int         STAT_PE      = 2;
  localparam int         STAT_TX_BUSY = 6;
  localparam int         STAT_RX_FULL = 7;
  localparam int         IRQ_TX_DONE  = 0;
  localparam int         IRQ_RX_DONE  = 1;
  localparam int         IRQ_PAR_ERR  = 2;
  localparam int         IRQ_W        = 3;
  localparam logic [1:0] MODE_SYNC    = 2'h1;
  localparam logic [1:0] PAR_EVEN     = 2'h2;
  localparam logic [1:0] PAR_ODD      = 2'h3;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------
  // Oversampling counts
  // ---------------------------------------------------------------
  localparam logic [3:0] OS_LAST_NORM = 4'hF;
  localparam logic [3:0] OS_LAST_DBL  = 4'h7;
  localparam logic [3:0] HALF_LAST_NORM = 4'h7;
  localparam logic [3:0] HALF_LAST_DBL  = 4'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] par_mode;
    logic       stop_two;
    logic [1:0] size_lo;
    logic       sync_pol;
  } ufb_fmt_s;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } ufb_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ufb_axi_rsp_s;

  typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_SHIFT = 2'h1} ufb_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3} ufb_rx_e;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Reserved size codes fall back to eight bits
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0:    return 4'h5;
      3'h1:    return 4'h6;
      3'h2:    return 4'h7;
      3'h7:    return 4'h9;
      default: return 4'h8;
    endcase
  endfunction

  function automatic logic calc_par(input logic [8:0] dat, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        p = p ^ dat[i];
    return p;
  endfunction

  function automatic logic [8:0] data_mask(input logic [8:0] dat, input logic [3:0] n);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        m[i] = dat[i];
    return m;
  endfunction

  // Start bit in bit 0, data LSB first, then parity, stop bits fill the rest
  function automatic logic [12:0] build_frame(input logic [8:0] dat, input logic [3:0] n,
                                              input logic pen, input logic par);
    logic [12:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        f[i+1] = dat[i];
    if (pen)
      f[n+4'h1] = par;
    return f;
  endfunction

endpackage

// File: hdl/ufb_baud_gen.sv
// Baud prescaler: down-counter reloaded from the divisor
`timescale 1ns/1ps
module ufb_baud_gen #(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // Divisor and reload
  input  wire logic [DIV_W-1:0] div,
  input  wire logic             load,
  // One pulse per divisor+1 cycles
  output logic                  tick
);
  import ufb_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } ufb_bg_state_s;

  ufb_bg_state_s q;
  ufb_bg_state_s d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (load)
    begin
      d.cnt = div; // R11
    end
    else if (q.cnt == '0)
    begin
      d.cnt = div; // R16
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
    load |=> (q.cnt == $past(div)) && !q.tick)
    else $error("Prescaler not reloaded by divisor write");

  AST_RATE: assert property (@(posedge sys_clk) disable iff (!nrst) // R16
    (q.cnt == '0 && !load) |=> q.tick && (q.cnt == $past(div)))
    else $error("Prescaler tick period wrong");

endmodule

// File: hdl/ufb_top.sv
// Serial frame format, parity and baud configuration with AXI4-Lite registers
//
// Summary of operation
// [R1] Parity field: 00 off, 01 reserved, 10 even, 11 odd, both directions.
// [R2] Transmitter appends computed parity bit to every frame when parity enabled.
// [R3] Receiver checks parity; mismatch sets the parity error flag for that character.
// [R4] Stop select 0 sends one stop bit, 1 sends two.
// [R5] Receiver ignores stop select; only transmit frame length depends on it.
// [R6] Size code gives 5,6,7,8 bits for 000-011, 9 for 111; others reserved.
// [R7] Software keeps clock polarity zero in asynchronous mode.
// [R8] Sync polarity 0: transmit on rising, sample on falling; 1 swaps edges.
// [R9] Baud divisor is 12 bits: four high, eight low.
// [R10] Upper four bits of divisor high register read as zero.
// [R11] Writing divisor low immediately reloads the prescaler with full divisor.
// [R12] Software avoids changing divisor while frames are in flight.
// [R13] Software prefers divisors within 0.5% of target rate.
// [R14] Double speed changes oversampling from 16 to 8 in asynchronous mode.
// [R15] Parity error flag describes unread character and holds until it is read.
// [R16] Asynchronous bit rate is clock over 16 (or 8) times divisor plus one.
`timescale 1ns/1ps
module ufb_top (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // Register bus
  input  wire ufb_pkg::ufb_axi_req_s axi_req,
  output ufb_pkg::ufb_axi_rsp_s      axi_rsp,
  // Serial pins
  input  wire logic                  serial_in_pin,
  output logic                       serial_out_pin,
  output logic                       sync_clock_pin,
  // Interrupt
  output logic                       irq
);
  import ufb_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ufb_axi_rsp_s     rsp;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       waddr;
    logic [31:0]      wdata;
    logic             wlane0;
    ufb_fmt_s         fmt;
    logic [DIV_W-1:0] div;
    logic             div_load;
    logic             size_hi;
    logic             tx_en;
    logic             rx_en;
    logic             dbl;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic             irq;
    ufb_tx_e          tx_state;
    logic [12:0]      tx_shift;
    logic [3:0]       tx_left;
    logic             txd_out;
    logic             xck;
    logic [3:0]       os_cnt;
    ufb_rx_e          rx_state;
    logic [3:0]       rx_os;
    logic [3:0]       rx_idx;
    logic [3:0]       rx_left;
    logic [9:0]       rx_shift;
    logic [8:0]       rx_data;
    logic             rx_full;
    logic             pe_flag;
  } ufb_state_s;

  ufb_state_s q;
  ufb_state_s d;

  logic       baud_tick;
  logic [3:0] n_bits;
  logic       par_en;
  logic       par_odd;
  logic       is_sync;
  logic [3:0] os_last;
  logic [3:0] half_last;
  logic       tx_stb;
  logic       rx_edge;
  logic       rx_stb;
  logic       wr_fire;
  logic       rd_fire;
  logic       tx_start;
  logic       rx_done;
  logic       rx_pe;

  // ---------------------------------------------------------------
  // Baud prescaler
  // ---------------------------------------------------------------
  ufb_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .div     (q.div),
    .load    (q.div_load),
    .tick    (baud_tick)
  );

  // ---------------------------------------------------------------
  // Decoded configuration
  // ---------------------------------------------------------------
  assign n_bits    = char_bits({q.size_hi, q.fmt.size_lo}); // R6
  assign par_en    = q.fmt.par_mode[1]; // R1
  assign par_odd   = q.fmt.par_mode[0];
  assign is_sync   = (q.fmt.mode == MODE_SYNC);
  assign os_last   = q.dbl ? OS_LAST_DBL : OS_LAST_NORM; // R14 R16
  assign half_last = q.dbl ? HALF_LAST_DBL : HALF_LAST_NORM;
  // Transmit moves on the edge that polarity picks; receive samples on the other
  assign tx_stb  = is_sync ? (baud_tick && (q.xck == q.fmt.sync_pol)) // R8
                           : (baud_tick && (q.os_cnt == os_last));
  assign rx_edge = baud_tick && (q.xck != q.fmt.sync_pol); // R8
  assign rx_stb  = is_sync ? rx_edge : (baud_tick && (q.rx_os == os_last));
  assign wr_fire = q.aw_got && q.w_got && !q.rsp.bvalid;
  assign rd_fire = axi_req.arvalid && q.rsp.arready;
  assign tx_start = wr_fire && q.wlane0 && (q.waddr == OFS_TXD) && (q.tx_state == TX_IDLE) && q.tx_en;
  assign rx_done = q.rx_en && (q.rx_state == RX_DATA) && rx_stb && (q.rx_left == 4'h1);
  assign rx_pe   = par_en && (q.rx_shift[n_bits] != calc_par(q.rx_shift[8:0], n_bits, par_odd)); // R3

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [IRQ_W-1:0] irq_set;
    logic [31:0]      rd;
    logic             rd_ok;
    irq_set = '0;
    rd = '0;
    rd_ok = 1'b1;
    d = q;
    d.div_load = 1'b0;

    // Bus channel bookkeeping
    if (q.rsp.bvalid && axi_req.bready)
      d.rsp.bvalid = 1'b0;
    if (q.rsp.rvalid && axi_req.rready)
      d.rsp.rvalid = 1'b0;
    if (axi_req.awvalid && q.rsp.awready)
    begin
      d.aw_got = 1'b1;
      d.waddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready)
    begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wlane0 = axi_req.wstrb[0];
    end

    // Bit clocks; the sync clock rests low outside synchronous mode
    if (baud_tick)
    begin
      d.xck = is_sync ? !q.xck : 1'b0; // R7
      d.os_cnt = (q.os_cnt == os_last) ? 4'h0 : q.os_cnt + 4'h1; // R14
    end

    // Transmitter
    unique case (q.tx_state)
      TX_IDLE:
      begin
        d.txd_out = 1'b1;
      end
      TX_SHIFT:
      begin
        if (tx_stb)
        begin
          if (q.tx_left == 4'h0)
          begin
            d.tx_state = TX_IDLE;
            irq_set[IRQ_TX_DONE] = 1'b1;
          end
          else
          begin
            d.txd_out = q.tx_shift[0];
            d.tx_shift = {1'b1, q.tx_shift[12:1]};
            d.tx_left = q.tx_left - 4'h1;
          end
        end
      end
    endcase

    // Register writes; bytes outside lane 0 are ignored, except bit 8 of a transmit data write
    if (wr_fire)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp = RESP_OKAY;
      unique case (q.waddr)
        OFS_FMT:
          if (q.wlane0)
            d.fmt = q.wdata[7:0];
        OFS_DIV_HI:
          if (q.wlane0)
            d.div[11:8] = q.wdata[3:0]; // R9 R10
        OFS_DIV_LO:
          if (q.wlane0)
          begin
            d.div[7:0] = q.wdata[7:0]; // R9
            d.div_load = 1'b1; // R11
          end
        OFS_CTRL:
          if (q.wlane0)
          begin
            d.size_hi = q.wdata[CTRL_SIZE_HI];
            d.tx_en = q.wdata[CTRL_TX_EN];
            d.rx_en = q.wdata[CTRL_RX_EN];
          end
        OFS_STAT:
          if (q.wlane0)
            d.dbl = q.wdata[STAT_DBL];
        OFS_TXD:
          if (tx_start)
          begin
            d.tx_state = TX_SHIFT;
            d.tx_shift = build_frame(q.wdata[8:0], n_bits, par_en, // R2 R4
                                     calc_par(q.wdata[8:0], n_bits, par_odd)); // R1
            d.tx_left = 4'(4'h2 + n_bits + {3'h0, par_en} + {3'h0, q.fmt.stop_two}); // R4
          end
        OFS_IRQ_ST:
          if (q.wlane0)
            d.irq_st = q.irq_st & ~q.wdata[IRQ_W-1:0];
        OFS_IRQ_MASK:
          if (q.wlane0)
            d.irq_mask = q.wdata[IRQ_W-1:0];
        OFS_RXD:
          d.rsp.bresp = RESP_OKAY;
        default:
          d.rsp.bresp = RESP_SLVERR;
      endcase
    end

    // Register reads; reading received data frees the buffer and its flag
    unique case (axi_req.araddr)
      OFS_FMT:      rd[7:0] = q.fmt;
      OFS_DIV_HI:   rd[7:0] = {4'h0, q.div[11:8]}; // R10
      OFS_DIV_LO:   rd[7:0] = q.div[7:0];
      OFS_CTRL:     rd[CTRL_RX_EN:CTRL_SIZE_HI] = {q.rx_en, q.tx_en, q.size_hi};
      OFS_STAT:
      begin
        rd[STAT_RX_FULL] = q.rx_full;
        rd[STAT_TX_BUSY] = (q.tx_state != TX_IDLE);
        rd[STAT_PE] = q.pe_flag; // R15
        rd[STAT_DBL] = q.dbl;
      end
      OFS_TXD:      rd = '0;
      OFS_RXD:      rd[8:0] = q.rx_data;
      OFS_IRQ_ST:   rd[IRQ_W-1:0] = q.irq_st;
      OFS_IRQ_MASK: rd[IRQ_W-1:0] = q.irq_mask;
      default:      rd_ok = 1'b0;
    endcase
    if (rd_fire)
    begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata = rd;
      d.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      if (axi_req.araddr == OFS_RXD)
      begin
        d.rx_full = 1'b0;
        d.pe_flag = 1'b0; // R15
      end
    end

    // Receiver; one stop bit whatever the stop select says
    if (!q.rx_en)
    begin
      d.rx_state = RX_IDLE;
      d.rx_full = 1'b0;
      d.pe_flag = 1'b0;
    end
    else
    begin
      unique case (q.rx_state)
        RX_IDLE:
        begin
          if ((is_sync ? rx_edge : baud_tick) && !serial_in_pin)
          begin
            d.rx_os = 4'h0;
            d.rx_idx = 4'h0;
            d.rx_left = 4'(n_bits + {3'h0, par_en} + 4'h1); // R5 R6
            d.rx_state = is_sync ? RX_DATA : RX_START;
          end
        end
        RX_START:
        begin
          if (baud_tick)
          begin
            d.rx_os = q.rx_os + 4'h1;
            if (q.rx_os == half_last) // R14
            begin
              d.rx_os = 4'h0;
              d.rx_state = serial_in_pin ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA:
        begin
          if (baud_tick && !is_sync)
            d.rx_os = (q.rx_os == os_last) ? 4'h0 : q.rx_os + 4'h1;
          if (rx_done)
          begin
            // A new character overwrites an unread one; set wins over the read
            d.rx_state = RX_IDLE;
            d.rx_data = data_mask(q.rx_shift[8:0], n_bits); // R6
            d.rx_full = 1'b1;
            d.pe_flag = rx_pe; // R3 R15
            irq_set[IRQ_RX_DONE] = 1'b1;
            irq_set[IRQ_PAR_ERR] = rx_pe; // R3
          end
          else if (rx_stb)
          begin
            d.rx_shift[q.rx_idx] = serial_in_pin;
            d.rx_idx = q.rx_idx + 4'h1;
            d.rx_left = q.rx_left - 4'h1;
          end
        end
      endcase
    end

    // Interrupts: a new event beats a simultaneous clear
    d.irq_st = d.irq_st | irq_set;
    d.irq = |(d.irq_st & d.irq_mask);
    d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
    d.rsp.wready = !d.w_got && !d.rsp.bvalid;
    d.rsp.arready = !d.rsp.rvalid;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.fmt <= FMT_RST;
      q.txd_out <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign axi_rsp        = q.rsp;
  assign serial_out_pin = q.txd_out;
  assign sync_clock_pin = q.xck;
  assign irq            = q.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_TX_ONE_STOP: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
    (tx_start && !q.fmt.stop_two && !par_en && n_bits == 4'h8) |=> q.tx_left == 4'hA)
    else $error("One stop bit frame has wrong length");

  AST_TX_TWO_STOP: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
    (tx_start && q.fmt.stop_two && !par_en && n_bits == 4'h8) |=> q.tx_left == 4'hB)
    else $error("Two stop bit frame has wrong length");

  AST_TX_EVEN: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
    (tx_start && q.fmt.par_mode == PAR_EVEN && n_bits == 4'h8) |=> q.tx_shift[9] == ^q.tx_shift[8:1])
    else $error("Even parity bit wrong");

  AST_TX_ODD: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
    (tx_start && q.fmt.par_mode == PAR_ODD && n_bits == 4'h5) |=> q.tx_shift[6] != ^q.tx_shift[5:1])
    else $error("Odd parity bit wrong");

  AST_RX_LEN: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
    (q.rx_state == RX_IDLE && d.rx_state != RX_IDLE && n_bits == 4'h8)
      |=> q.rx_left == ($past(par_en) ? 4'hA : 4'h9))
    else $error("Receive frame length depends on wrong setting");

  AST_PE_SET: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
    (rx_done && rx_pe) |=> q.pe_flag && q.rx_full && q.irq_st[IRQ_PAR_ERR])
    else $error("Parity mismatch not flagged");

  AST_PE_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
    (q.rx_full && q.rx_en && !rx_done && !(rd_fire && axi_req.araddr == OFS_RXD)) |=> $stable(q.pe_flag))
    else $error("Parity flag changed before character read");

  AST_SYNC_EDGE: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
    (is_sync && $stable(q.fmt) && $changed(q.txd_out)) |-> (q.fmt.sync_pol ? $fell(q.xck) : $rose(q.xck)))
    else $error("Sync transmit data changed on wrong clock edge");

  AST_DIV_HI_READ: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
    (rd_fire && axi_req.araddr == OFS_DIV_HI) |=> q.rsp.rdata[7:0] == {4'h0, $past(q.div[11:8])})
    else $error("Divisor high readback wrong");

  AST_DIV_LO_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
    (wr_fire && q.wlane0 && q.waddr == OFS_DIV_LO) |=> q.div_load ##1 !q.div_load)
    else $error("Divisor low write did not reload prescaler");

  AST_OS_DOUBLE: assert property (@(posedge sys_clk) disable iff (!nrst) // R14
    (baud_tick && !is_sync && q.dbl && q.os_cnt == 4'h7) |=> q.os_cnt == 4'h0)
    else $error("Double speed oversampling not eight");

endmodule

// File: verif/ufb_peer.sv
// Remote serial peer: drives the receive line and captures the transmit line
`timescale 1ns/1ps
module ufb_peer (
  // Clock
  input  wire logic sys_clk,
  // Serial lines
  input  wire logic tx_line,
  output logic      rx_line
);
  int          bit_len = 32;
  logic [12:0] got;
  logic        cap = 1'b0;
  time         t_fall = 0;
  initial rx_line = 1'b1;
  // Start low, LSB first, idle high after the frame
  task automatic send(input logic [12:0] f, input int nb);
    for (int i = 0; i < nb; i++)
    begin
      rx_line <= f[i];
      repeat (bit_len) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
  endtask
  // Mid-bit sampling; a wrong bit rate shows up as a wrong pattern
  always
  begin
    @(negedge tx_line);
    t_fall = $time;
    cap = 1'b1;
    repeat (bit_len / 2) @(posedge sys_clk);
    for (int i = 0; i < 13; i++)
    begin
      got[i] = tx_line;
      repeat (bit_len) @(posedge sys_clk);
    end
    cap = 1'b0;
  end
endmodule

// File: verif/test_ufb_top.sv
// Testbench: registers, frame format, bit timing, parity and interrupt
`timescale 1ns/1ps
module test_ufb_top;
  import ufb_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int DIV = 1;
  localparam int BIT = 16 * (DIV + 1);
  localparam logic [14:0] CASES [8] = '{{3'h0, 2'h3, 1'b0, 9'h1B5}, {3'h1, 2'h2, 1'b1, 9'h0CA},
    {3'h2, 2'h0, 1'b0, 9'h07F}, {3'h3, 2'h1, 1'b1, 9'h0A5}, {3'h7, 2'h2, 1'b1, 9'h13C},
    {3'h5, 2'h2, 1'b0, 9'h0E1}, {3'h4, 2'h0, 1'b0, 9'h0C3}, {3'h3, 2'h2, 1'b0, 9'h05A}};
  logic         sys_clk;
  logic         nrst;
  ufb_axi_req_s req;
  ufb_axi_rsp_s rsp;
  logic         rx_line;
  logic         tx_line;
  logic         irq;
  logic         xck;
  logic [31:0]  d;
  logic [1:0]   r;
  int           miscompares = 0;
  int           checks_done = 0;
  ufb_top i_ufb_top (.sys_clk(sys_clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp), .serial_in_pin(rx_line),
    .serial_out_pin(tx_line), .sync_clock_pin(xck), .irq(irq));
  ufb_peer i_ufb_peer (.sys_clk(sys_clk), .tx_line(tx_line), .rx_line(rx_line));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Each valid drops at the edge its ready is seen high
  task automatic wr(input logic [7:0] a, input logic [8:0] v);
    logic b;
    b = 1'b0;
    req.awaddr <= a;
    req.wdata <= {23'h0, v};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!b)
    begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      b = rsp.bvalid;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic b;
    b = 1'b0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    while (!b)
    begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      b = rsp.rvalid;
    end
    d = rsp.rdata;
    r = rsp.rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, d, e);
  endtask
  function automatic int nb(input logic [2:0] c);
    return (c == 3'h7) ? 9 : (c[2] ? 8 : 5 + int'(c[1:0]));
  endfunction
  function automatic logic [12:0] ef(input logic [8:0] v, input int n, input logic [1:0] pm);
    logic [12:0] f;
    logic        p;
    f = '1;
    f[0] = 1'b0;
    p = pm[0];
    for (int i = 0; i < n; i++)
    begin
      f[i+1] = v[i];
      p = p ^ v[i];
    end
    if (pm[1])
      f[n+1] = p;
    return f;
  endfunction
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [2:0] code;
    logic [1:0] pm;
    logic       two;
    logic [8:0] dat;
    int         w;
    int         n;
    int         k0;
    nrst = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    i_ufb_peer.bit_len = BIT;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rc(OFS_FMT, 32'h06, "format reset");
    rc(OFS_DIV_LO, 32'h00, "divisor low reset");
    wr(OFS_DIV_HI, 9'h0FF);
    rc(OFS_DIV_HI, 32'h0F, "divisor high");
    rd(8'h40);
    chk("unmapped resp", r, RESP_SLVERR);
    wr(OFS_DIV_HI, 9'h000);
    wr(OFS_DIV_LO, 9'(DIV));
    rc(OFS_DIV_LO, DIV, "divisor low");
    wr(OFS_IRQ_MASK, 9'h001);
    // Case 6 runs at double speed, case 7 in synchronous mode with polarity one
    for (int i = 0; i < 8; i++)
    begin
      {code, pm, two, dat} = CASES[i];
      if (i >= 6)
      begin
        wr(OFS_STAT, {7'h0, i == 6, 1'b0});
        i_ufb_peer.bit_len = (i == 6) ? 8 * (DIV + 1) : 2 * (DIV + 1);
      end
      wr(OFS_FMT, {2'h0, i == 7, pm, two, code[1:0], i == 7});
      wr(OFS_CTRL, {4'h0, 2'h3, code[2], 2'h0});
      wr(OFS_TXD, dat);
      w = 0;
      while (irq !== 1'b1 && w < 2000)
      begin
        @(posedge sys_clk);
        w++;
      end
      chk("tx done irq", irq, 1'b1);
      n = int'(($time - i_ufb_peer.t_fall) / 40) - (2 + nb(code) + int'(pm[1]) + int'(two)) * BIT;
      wait (i_ufb_peer.cap === 1'b0);
      chk("tx frame", i_ufb_peer.got, ef(dat, nb(code), pm));
      if (i == 0)
        k0 = n;
      else if (i < 6)
        chk("frame length", n, k0);
      wr(OFS_IRQ_ST, 9'h001);
      repeat (2) @(posedge sys_clk);
      chk("irq cleared", irq, 1'b0);
    end
    // Two stop bits selected, one sent: receiver must not care
    i_ufb_peer.bit_len = BIT;
    wr(OFS_FMT, 9'h02E);
    for (int j = 0; j < 2; j++)
    begin
      i_ufb_peer.send({3'h7, j[0], 8'h5A, 1'b0}, 11);
      rd(OFS_STAT);
      chk("parity flag", d[2], j[0]);
      rc(OFS_IRQ_ST, {29'h0, j[0], 2'h2}, "irq status");
      chk("irq masked", irq, 1'b0);
      chk("sync clock idle", xck, 1'b0);
      wr(OFS_IRQ_MASK, {6'h0, j[0], 2'h1});
      repeat (2) @(posedge sys_clk);
      chk("irq raised", irq, j[0]);
      rc(OFS_RXD, 32'h5A, "rx data");
      rd(OFS_STAT);
      chk("parity flag read", d[2], 1'b0);
      wr(OFS_IRQ_ST, 9'h006);
      repeat (2) @(posedge sys_clk);
      chk("irq after clear", irq, 1'b0);
    end
    report_and_stop;
  end
  // Whole run needs well under ten thousand cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop;
  end
endmodule
